// ==== rtl/dsbi_defines.vh ====
// Constants for the delta-sigma bitstream interface.
// Assumes inclusion by bare name from the rtl/ files only.
`ifndef DSBI_DEFINES_VH
`define DSBI_DEFINES_VH

// Interface modes, high select bit first
`define DSBI_MODE_SYNC 2'h0
`define DSBI_MODE_HALF 2'h1
`define DSBI_MODE_MANCH 2'h2
`define DSBI_MODE_EXT 2'h3

// Phases of one modulator period, counted in system half periods
`define DSBI_PH_W 2
`define DSBI_PH_FIRST 2'h0
`define DSBI_PH_MOD_FALL 2'h2
`define DSBI_PH_EXT_UPD 2'h3
`define DSBI_PH_STEP 2'h1

// Clock rates in kHz
`define DSBI_SYS_FREQ_KHZ 18'h04E20
`define DSBI_CLK_FREQ_KHZ 18'h3D090
`define DSBI_ACC_W 18
`define DSBI_EXT_MIN_KHZ 1000
`define DSBI_EXT_MAX_KHZ 32000

// Modulator datapath
`define DSBI_IN_W 16
`define DSBI_INT_W 24
`define DSBI_FB_LEVEL 24'h007FFF
`define DSBI_BUF_DEPTH 2
`define DSBI_BUF_AW 1

`endif

// ==== rtl/dsbi_buf2.v ====
// Small valid/ready buffer between modulator and output serializer.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module dsbi_buf2 #(
  parameter W = 1,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  integer i;

  function [AW-1:0] ptr_next;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        ptr_next = {AW{1'b0}};
      end else begin
        ptr_next = p + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  assign in_ready_o = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ==== rtl/dsbi_top.v ====
// Delta-sigma bitstream interface: modulator core and mode-driven output.
// Assumes all pins synchronous to mclk_i (250 MHz); the system clock and
// the external clock pin are modelled as half-period events on mclk_i.
`timescale 1ns/1ps
`include "dsbi_defines.vh"

// Functional notes
// - Mode select pins decode to modes 0..3, high select bit first.
// - Modes 0 to 2 run from internal oscillator at 20 MHz.
// - Modulator clock is system clock divided by two in every mode.
// - Mode 3 external clock 1 to 32 MHz, modulator 500 kHz to 16 MHz.
// - Clock pin is driven in modes 0 to 2, input in mode 3.
// - Mode 0 drives modulator clock; data changes on its falling edge.
// - Mode 1 drives half modulator clock; pin at 5 MHz, data at 10 Mbit/s.
// - Mode 1 data changes midway between clock edges.
// - Mode 2 sends Manchester-coded data on the single data line.
// - Mode 2 holds the clock pin low with no clock output.
// - Mode 3 stops the oscillator and takes system clock from pin.
// - Mode 3 data changes on every second external falling edge.
// - Mode 3 drives modulator clock on divided clock output pin.
// - Ones density 50% at zero, 80% at +256 mV, 20% at -256 mV.
// - Divided clock output is driven only in mode 3.
module dsbi_top #(
  parameter [`DSBI_ACC_W-1:0] SYS_FREQ_KHZ = `DSBI_SYS_FREQ_KHZ,
  parameter [`DSBI_ACC_W-1:0] CLK_FREQ_KHZ = `DSBI_CLK_FREQ_KHZ,
  parameter IN_W = `DSBI_IN_W,
  parameter INT_W = `DSBI_INT_W
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire mode_sel_low_bit_i,
  input wire mode_sel_high_bit_i,
  input wire signed [IN_W-1:0] ain_i,
  input wire clk_pin_i,
  output wire clk_pin_o,
  output wire clk_pin_oe_o,
  output wire bitstream_out_o,
  output wire divided_clock_output_o,
  output wire divided_clock_output_oe_o,
  output wire osc_en_o,
  output wire [1:0] mode_o,
  output wire underrun_o
);

  localparam [`DSBI_ACC_W:0] OSC_STEP = {SYS_FREQ_KHZ, 1'b0};
  localparam [`DSBI_ACC_W:0] OSC_LIM = {1'b0, CLK_FREQ_KHZ};

  // Feedback level of the one-bit DAC, signed, at integrator width
  function signed [INT_W-1:0] dac_level;
    input b;
    begin
      if (b) begin
        dac_level = `DSBI_FB_LEVEL;
      end else begin
        dac_level = -`DSBI_FB_LEVEL;
      end
    end
  endfunction

  // Phase at which a new bit is taken for the given mode
  function [`DSBI_PH_W-1:0] upd_phase;
    input [1:0] m;
    begin
      case (m)
        `DSBI_MODE_SYNC: upd_phase = `DSBI_PH_MOD_FALL;
        `DSBI_MODE_HALF: upd_phase = `DSBI_PH_MOD_FALL;
        `DSBI_MODE_MANCH: upd_phase = `DSBI_PH_FIRST;
        `DSBI_MODE_EXT: upd_phase = `DSBI_PH_EXT_UPD;
        default: upd_phase = `DSBI_PH_FIRST;
      endcase
    end
  endfunction

  // True in the external-clock mode
  function is_ext;
    input [1:0] m;
    begin
      is_ext = (m == `DSBI_MODE_EXT);
    end
  endfunction

  // Manchester line level: a one is low in the first half, high after
  function manch_level;
    input b;
    input [`DSBI_PH_W-1:0] p;
    begin
      manch_level = b ? p[`DSBI_PH_W-1] : ~p[`DSBI_PH_W-1];
    end
  endfunction

  // Mode decode
  reg [1:0] mode_q;
  wire [1:0] mode_d;
  wire mode_chg;
  wire ext_mode;

  assign mode_d = {mode_sel_high_bit_i, mode_sel_low_bit_i};
  assign mode_chg = (mode_d != mode_q);
  assign ext_mode = is_ext(mode_q);

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= `DSBI_MODE_SYNC;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Internal oscillator: fractional accumulator giving 40 M half-periods/s
  reg [`DSBI_ACC_W-1:0] osc_acc_q;
  wire [`DSBI_ACC_W:0] osc_sum;
  wire osc_tick;
  wire [`DSBI_ACC_W:0] osc_wrap;

  assign osc_sum = {1'b0, osc_acc_q} + OSC_STEP;
  assign osc_tick = ~ext_mode & (osc_sum >= OSC_LIM);
  assign osc_wrap = osc_sum - OSC_LIM;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_acc_q <= {`DSBI_ACC_W{1'b0}};
    end else if (ext_mode) begin
      osc_acc_q <= {`DSBI_ACC_W{1'b0}};
    end else if (osc_tick) begin
      osc_acc_q <= osc_wrap[`DSBI_ACC_W-1:0];
    end else begin
      osc_acc_q <= osc_sum[`DSBI_ACC_W-1:0];
    end
  end

  // External system clock edges, pin already synchronous
  reg ext_lvl_q;
  wire ext_rise;
  wire ext_fall;

  assign ext_rise = ext_mode & clk_pin_i & ~ext_lvl_q;
  assign ext_fall = ext_mode & ~clk_pin_i & ext_lvl_q;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_lvl_q <= 1'b0;
    end else begin
      ext_lvl_q <= clk_pin_i;
    end
  end

  // Phase within one modulator period: four system half periods
  reg [`DSBI_PH_W-1:0] ph_q;
  reg [`DSBI_PH_W-1:0] ph_d;
  wire [`DSBI_PH_W-1:0] ph_inc;
  wire half_tick;

  assign half_tick = osc_tick | ext_rise | ext_fall;
  assign ph_inc = ph_q + `DSBI_PH_STEP;

  always @* begin
    ph_d = ph_q;
    if (half_tick) begin
      if (ext_rise) begin
        // System rising edges always land on even phases
        ph_d = {ph_inc[`DSBI_PH_W-1], 1'b0};
      end else begin
        ph_d = ph_inc;
      end
    end
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_q <= `DSBI_PH_FIRST;
    end else if (mode_chg) begin
      ph_q <= `DSBI_PH_FIRST;
    end else begin
      ph_q <= ph_d;
    end
  end

  // Modulator clock is high in the first system period of each phase cycle
  wire mod_clk_d;
  wire upd;
  wire ph_first;

  assign mod_clk_d = ~ph_d[`DSBI_PH_W-1];
  assign upd = half_tick & ~mode_chg & (ph_d == upd_phase(mode_q));
  // Start of a modulator period, where the half-rate clock toggles
  assign ph_first = half_tick & (ph_d == `DSBI_PH_FIRST);

  // Second-order modulator, stalled by the buffer
  reg signed [INT_W-1:0] int1_q;
  reg signed [INT_W-1:0] int2_q;
  wire signed [INT_W-1:0] ain_ext;
  wire signed [INT_W-1:0] fb;
  wire signed [INT_W-1:0] int1_d;
  wire signed [INT_W-1:0] int2_d;
  wire mod_bit;
  wire buf_in_ready;

  assign ain_ext = {{(INT_W-IN_W){ain_i[IN_W-1]}}, ain_i};
  assign mod_bit = ~int2_q[INT_W-1];
  assign fb = dac_level(mod_bit);
  // Density is 1/2 + x/(2 * feedback level), so 0.6 of it gives 80%
  assign int1_d = int1_q + ain_ext - fb;
  assign int2_d = int2_q + int1_d - fb;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int1_q <= {INT_W{1'b0}};
      int2_q <= {INT_W{1'b0}};
    end else if (buf_in_ready) begin
      int1_q <= int1_d;
      int2_q <= int2_d;
    end
  end

  // Two-entry buffer between modulator and output serializer
  wire buf_out_valid;
  wire buf_out_data;

  dsbi_buf2 #(
    .W(1),
    .DEPTH(`DSBI_BUF_DEPTH),
    .AW(`DSBI_BUF_AW)
  ) u_buf (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(1'b1),
    .in_ready_o(buf_in_ready),
    .in_data_i(mod_bit),
    .out_valid_o(buf_out_valid),
    .out_ready_i(upd),
    .out_data_o(buf_out_data)
  );

  // Current bit; held when the buffer runs dry
  reg cur_bit_q;
  reg underrun_q;
  wire next_bit;

  assign next_bit = (upd & buf_out_valid) ? buf_out_data : cur_bit_q;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_bit_q <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      cur_bit_q <= next_bit;
      underrun_q <= upd & ~buf_out_valid;
    end
  end

  // Pin drive per mode
  reg clk_pin_q;
  reg clk_pin_d;
  reg clk_oe_q;
  reg half_clk_q;
  reg half_clk_d;
  reg data_q;
  reg data_d;
  reg div_clk_q;
  reg div_clk_d;
  reg div_oe_q;
  wire clk_oe_d;
  wire div_oe_d;

  // Pin directions track the raw mode pins, landing with mode_q
  assign clk_oe_d = ~is_ext(mode_d);
  assign div_oe_d = is_ext(mode_d);

  always @* begin
    clk_pin_d = clk_pin_q;
    half_clk_d = half_clk_q;
    data_d = data_q;
    div_clk_d = 1'b0;
    case (mode_q)
      `DSBI_MODE_SYNC: begin
        clk_pin_d = mod_clk_d;
        if (upd) begin
          data_d = next_bit;
        end
      end
      `DSBI_MODE_HALF: begin
        if (ph_first) begin
          half_clk_d = ~half_clk_q;
        end
        clk_pin_d = half_clk_d;
        if (upd) begin
          data_d = next_bit;
        end
      end
      `DSBI_MODE_MANCH: begin
        clk_pin_d = 1'b0;
        // One: low then high; zero: high then low
        if (half_tick) begin
          data_d = manch_level(next_bit, ph_d);
        end
      end
      `DSBI_MODE_EXT: begin
        clk_pin_d = 1'b0;
        div_clk_d = mod_clk_d;
        if (upd) begin
          data_d = next_bit;
        end
      end
      default: begin
        clk_pin_d = 1'b0;
      end
    endcase
    if (mode_chg) begin
      half_clk_d = 1'b0;
    end
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_pin_q <= 1'b0;
      clk_oe_q <= 1'b0;
      half_clk_q <= 1'b0;
      data_q <= 1'b0;
      div_clk_q <= 1'b0;
      div_oe_q <= 1'b0;
    end else begin
      clk_pin_q <= clk_pin_d;
      clk_oe_q <= clk_oe_d;
      half_clk_q <= half_clk_d;
      data_q <= data_d;
      div_clk_q <= div_clk_d;
      div_oe_q <= div_oe_d;
    end
  end

  assign clk_pin_o = clk_pin_q;
  assign clk_pin_oe_o = clk_oe_q;
  assign bitstream_out_o = data_q;
  assign divided_clock_output_o = div_clk_q;
  assign divided_clock_output_oe_o = div_oe_q;
  assign osc_en_o = ~ext_mode;
  assign mode_o = mode_q;
  assign underrun_o = underrun_q;

endmodule

// ==== sim/dsbi_monitor.sv ====
// Pin checker for dsbi_top, bound to its ports.
// Assumes mode pins stay put long enough to judge each mode.
`timescale 1ns/1ps
module dsbi_monitor (
  input wire mclk_i,
  input wire rstn_i,
  input wire mode_sel_low_bit_i,
  input wire mode_sel_high_bit_i,
  input wire clk_pin_o,
  input wire clk_pin_oe_o,
  input wire bitstream_out_o,
  input wire divided_clock_output_o,
  input wire divided_clock_output_oe_o,
  input wire osc_en_o,
  input wire [1:0] mode_o,
  input wire underrun_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  reg [1:0] mode_q;
  reg [3:0] held_q;
  reg bit_q;
  reg [5:0] still_q;
  wire st = held_q == 4'hF;
  wire chg = bitstream_out_o != bit_q;
  // Steady-mode age and Manchester quiet time
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 2'h0;
      held_q <= 4'h0;
      bit_q <= 1'b0;
      still_q <= 6'h00;
    end else begin
      mode_q <= mode_o;
      held_q <= (mode_o != mode_q) ? 4'h0 : held_q + {3'h0, !st};
      bit_q <= bitstream_out_o;
      still_q <= (mode_o != 2'h2 || chg) ? 6'h00 :
        still_q + {5'h00, still_q != 6'h3F};
    end
  end
  a_mode_decode: assert property ($past(rstn_i) |->
    mode_o == $past({mode_sel_high_bit_i, mode_sel_low_bit_i}))
    else $error("mode decode wrong");
  a_pin_dir: assert property ($past(rstn_i) |->
    clk_pin_oe_o == (mode_o != 2'h3)) else $error("clock pin dir wrong");
  a_div_oe: assert property (
    divided_clock_output_oe_o == (mode_o == 2'h3)) else $error("div oe");
  a_osc_stop: assert property (
    osc_en_o != (mode_o == 2'h3)) else $error("oscillator enable wrong");
  a_manch_noclk: assert property (st && mode_o == 2'h2 |->
    !clk_pin_o) else $error("clock seen in mode 2");
  a_div_idle: assert property (st && mode_o != 2'h3 |->
    !divided_clock_output_o) else $error("div clock outside mode 3");
  a_sync_fall: assert property (st && mode_o == 2'h0 && chg |->
    $fell(clk_pin_o)) else $error("mode 0 data off falling edge");
  a_half_mid: assert property (st && mode_o == 2'h1 && chg |->
    $stable(clk_pin_o)) else $error("mode 1 data on clock edge");
  a_ext_upd: assert property (st && mode_o == 2'h3 && chg |->
    !divided_clock_output_o && !$past(divided_clock_output_o))
    else $error("mode 3 data off its edge");
  a_manch_mid: assert property (still_q < 6'h20)
    else $error("no mid-bit transition");
  a_no_underrun: assert property (!underrun_o)
    else $error("bit repeated on buffer underrun");
endmodule

bind dsbi_top dsbi_monitor u_dsbi_monitor (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .mode_sel_low_bit_i(mode_sel_low_bit_i),
  .mode_sel_high_bit_i(mode_sel_high_bit_i), .clk_pin_o(clk_pin_o),
  .clk_pin_oe_o(clk_pin_oe_o), .bitstream_out_o(bitstream_out_o),
  .divided_clock_output_o(divided_clock_output_o),
  .divided_clock_output_oe_o(divided_clock_output_oe_o),
  .osc_en_o(osc_en_o), .mode_o(mode_o), .underrun_o(underrun_o));

// ==== sim/dsbi_rx_model.sv ====
// Receiving filter: external clock source in mode 3 and bit sampler.
// Assumes pins seen on mclk_i; the bench tells it the mode.
`timescale 1ns/1ps
module dsbi_rx_model (
  input wire mclk_i,
  input wire clr_i,
  input wire [1:0] mode_i,
  input wire [3:0] half_i,
  input wire pin_clk_i,
  input wire pin_dat_i,
  input wire div_clk_i,
  output wire ext_o,
  output integer ones_o,
  output integer cnt_o
);
  reg ext_q = 1'b0;
  reg flt_q = 1'b0;
  reg clk_d = 1'b0;
  reg div_d = 1'b0;
  integer ph = 0;
  reg dat_d = 1'b0;
  integer gap = 0;
  wire rise = pin_clk_i && !clk_d;
  // Manchester: an edge well after the last mid-bit edge is mid-bit
  wire man = mode_i == 2'h2 && pin_dat_i != dat_d && gap >= 18;
  wire samp = (mode_i == 2'h0 && rise)
    || (mode_i == 2'h1 && pin_clk_i != clk_d)
    || (mode_i == 2'h2 && (man || rise))
    || (mode_i == 2'h3 && div_clk_i && !div_d);
  // Released line toggles so no stale level is read
  assign ext_o = (mode_i == 2'h3) ? ext_q : flt_q;
  always @(posedge mclk_i) begin
    clk_d <= pin_clk_i;
    div_d <= div_clk_i;
    dat_d <= pin_dat_i;
    gap <= man ? 1 : gap + 1;
    flt_q <= ~flt_q;
    ph <= (ph + 1 >= half_i) ? 0 : ph + 1;
    if (ph + 1 >= half_i)
      ext_q <= ~ext_q;
    if (clr_i) begin
      ones_o <= 0;
      cnt_o <= 0;
    end else if (samp) begin
      ones_o <= ones_o + pin_dat_i;
      cnt_o <= cnt_o + 1;
    end
  end
endmodule

// ==== sim/test_dsbi_top.sv ====
// Bench for dsbi_top: mode table, bit rates and ones density per mode.
// Assumes dsbi_monitor bound in and dsbi_rx_model as the receiver.
`timescale 1ns/1ps
module test_dsbi_top;
  reg mclk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [1:0] mode = 2'h0;
  reg signed [15:0] ain = 16'sh0000;
  reg [3:0] half = 4'h4;
  reg clr = 1'b1;
  wire clk_o, clk_oe, dat, div, div_oe, osc, unf, ext;
  wire [1:0] mode_o;
  wire clk_wire = clk_oe ? clk_o : ext;
  integer ones, cnt, expc;
  integer num_errors = 0;
  integer total_checks = 0;
  integer unf_seen = 0;
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (rstn_i && unf !== 1'b0)
      unf_seen <= unf_seen + 1;
  dsbi_top u_dsbi_top (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .mode_sel_low_bit_i(mode[0]), .mode_sel_high_bit_i(mode[1]),
    .ain_i(ain), .clk_pin_i(clk_wire), .clk_pin_o(clk_o),
    .clk_pin_oe_o(clk_oe), .bitstream_out_o(dat),
    .divided_clock_output_o(div), .divided_clock_output_oe_o(div_oe),
    .osc_en_o(osc), .mode_o(mode_o), .underrun_o(unf));
  dsbi_rx_model u_dsbi_rx_model (.mclk_i(mclk_i), .clr_i(clr),
    .mode_i(mode), .half_i(half), .pin_clk_i(clk_wire),
    .pin_dat_i(dat), .div_clk_i(div), .ext_o(ext), .ones_o(ones),
    .cnt_o(cnt));
  task chk(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] tol = 0);
    total_checks = total_checks + 1;
    if (^got === 1'bx || got > exp + tol || got + tol < exp) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Settle in a mode, then count bits over 5000 cycles (20 us)
  task run(input [1:0] m, input signed [15:0] a, input [3:0] h);
    @(negedge mclk_i);
    mode = m;
    ain = a;
    half = h;
    clr = 1'b1;
    repeat (200) @(negedge mclk_i);
    chk(mode_o, m);
    chk(clk_oe, m != 2'h3);
    chk(div_oe, m == 2'h3);
    chk(osc, m != 2'h3);
    clr = 1'b0;
    repeat (5000) @(negedge mclk_i);
    expc = (m == 2'h3) ? 5000 / (4 * h) : 200;
    chk(cnt, expc, 2);
    if (expc > 0)
      chk(ones, (983000 + 30 * a) * cnt / 1966000, cnt / 25 + 2);
    chk(unf_seen, 0);
    $display("done mode %0d ain %0d bits %0d", m, a, cnt);
  endtask
  initial begin
    void'($urandom(32'h9335350C));
    repeat (10) @(negedge mclk_i);
    rstn_i = 1'b1;
    run(2'h0, 16'sh0000, 4'h4);
    run(2'h0, 16'sh4CCC, 4'h4);
    run(2'h0, -16'sh4CCC, 4'h4);
    run(2'h1, $urandom_range(39320) - 19660, 4'h4);
    run(2'h2, $urandom_range(39320) - 19660, 4'h4);
    run(2'h3, $urandom_range(39320) - 19660, 4'h4);
    rstn_i = 1'b0;
    @(negedge mclk_i);
    chk(mode_o, 2'h0);
    chk(clk_oe, 1'b0);
    chk(osc, 1'b1);
    rstn_i = 1'b1;
    run(2'h3, $urandom_range(39320) - 19660, 4'h9);
    run(2'h1, -16'sh4CCC, 4'h4);
    results;
  end
  initial begin
    #400000;
    num_errors = num_errors + 1;
    results;
  end
endmodule
